// ===== dv/bst_tester.sv
// tester model driving the test access pins and collecting serial output
`timescale 1ns/1ps

module bst_tester (
  // pacing
  input  wire logic clock,
  // serial answer
  input  wire logic ser_out,
  input  wire logic ser_out_oe,
  // test access pins
  output logic      test_clock_alt,
  output logic      mode_sel,
  output logic      ser_in
);
  initial begin
    test_clock_alt = 1'b0;
    mode_sel       = 1'b1;
    ser_in         = 1'b0;
  end

  // levels hold four clocks either side of the rise, above the sync latency;
  // a floating serial output reads unknown so it can never pass a compare
  task automatic tick(input logic m, input logic d, output logic o);
    mode_sel = m;
    ser_in   = d;
    repeat (4) @(negedge clock);
    o = ser_out_oe ? ser_out : 1'bx;
    test_clock_alt = 1'b1;
    repeat (4) @(negedge clock);
    test_clock_alt = 1'b0;
  endtask

  task automatic enter(input logic ir_path);
    logic b;
    tick(1'b1, 1'b0, b);
    if (ir_path) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask

  task automatic shift(input int n, input logic [32:0] d, output logic [32:0] q,
                       input logic upd);
    logic b;
    q = '0;
    for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
    if (upd) begin
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
    end
  endtask

  task automatic ir(input logic [3:0] op, output logic [32:0] q);
    enter(1'b1);
    shift(4, {29'h0, op}, q, 1'b1);
  endtask

  task automatic dr(input int n, input logic [32:0] d, output logic [32:0] q);
    enter(1'b0);
    shift(n, d, q, 1'b1);
  endtask

  // reset without the optional pin
  task automatic reset5();
    logic b;
    repeat (5) tick(1'b1, 1'b0, b);
  endtask
endmodule

// ===== dv/test_boundary_scan_tap.sv
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps

module test_boundary_scan_tap;
  // identification fields, values arbitrary
  localparam logic [3:0]  VER    = 4'h3;
  localparam logic [15:0] PART   = 16'h1234;
  localparam logic [10:0] MFR    = 11'h155;
  localparam logic [32:0] ID_EXP = {1'b0, VER, PART, MFR, bst_pkg::ID_LSB_ONE};
  localparam logic [31:0] CAP_B  = 32'hc59;
  typedef struct packed {
    logic [3:0]  op;
    logic [5:0]  len;
    logic [31:0] cap;
  } bst_row_t;

  logic        clock;
  logic        nrst;
  logic        ce;
  logic        test_rst_n;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        ser_out;
  logic        ser_out_oe;
  logic [3:0]  core_out;
  logic [3:0]  core_oe;
  logic [3:0]  core_in;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic        b;
  logic [32:0] din;
  logic [32:0] got;
  logic [32:0] e;
  int          error_cnt;
  int          check_count;
  int          cyc;
  bst_row_t    rows[8];

  bst_tap #(.ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR)) u_bst_tap (
    .clock(clock), .nrst(nrst), .ce(ce), .test_clock_alt(tck), .mode_sel(tms),
    .ser_in(tdi), .test_rst_n(test_rst_n), .ser_out(ser_out), .ser_out_oe(ser_out_oe),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));

  bst_tester u_bst_tester (
    .clock(clock), .ser_out(ser_out), .ser_out_oe(ser_out_oe),
    .test_clock_alt(tck), .mode_sel(tms), .ser_in(tdi));

  task automatic chk(input logic [32:0] g, input logic [32:0] x, input string m);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // a full run needs about 4700 clocks
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      final_report();
    end
  end

  initial begin
    nrst = 1'b0; ce = 1'b1; test_rst_n = 1'b1;
    core_out = 4'h5; core_oe = 4'hc; pin_in = 4'h9;
    error_cnt = 0; check_count = 0; din = 33'h1_a5c3_9e71;
    rows = '{'{4'h0, 6'd12, CAP_B}, '{4'h1, 6'd12, CAP_B}, '{4'h2, 6'd32, ID_EXP[31:0]},
             '{4'h3, 6'd1, 32'h0}, '{4'h4, 6'd1, 32'h0}, '{4'ha, 6'd1, 32'h0},
             '{4'he, 6'd1, 32'h0}, '{4'hf, 6'd1, 32'h0}};
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    u_bst_tester.tick(1'b0, 1'b0, b);
    u_bst_tester.dr(32, din, got);
    chk(got, ID_EXP, "id after reset");
    $display("power-up test done");
    foreach (rows[i]) begin
      u_bst_tester.ir(rows[i].op, got);
      chk(got, 33'(bst_pkg::IR_CAPTURE), "ir capture");
      chk(33'(ser_out_oe), 33'h0, "idle drive");
      u_bst_tester.dr(33, din, got);
      e = (din << rows[i].len) | 33'(rows[i].cap);
      chk(got, e, "dr scan");
      e = (rows[i].op == bst_pkg::OP_EXTEST) ? {25'h0, din[32:25]} : {25'h0, core_oe, core_out};
      got = {25'h0, pin_oe, pin_out};
      if (rows[i].op == bst_pkg::OP_HIGHZ) begin
        e = 33'h0;
        got[3:0] = 4'h0;
      end
      chk(got, e, "pads");
      chk(33'(core_in), 33'(pin_in), "core in");
      $display("row %0d done", i);
    end
    // mode-select reset from exit1-dr of a boundary scan; cells differ from core values
    u_bst_tester.ir(bst_pkg::OP_EXTEST, got);
    chk({25'h0, pin_oe, pin_out}, {25'h0, din[32:25]}, "extest pads");
    u_bst_tester.enter(1'b0);
    u_bst_tester.shift(12, din >> 21, got, 1'b0);
    chk(got, 33'(CAP_B), "extest capture");
    u_bst_tester.reset5();
    chk({25'h0, pin_oe, pin_out}, {25'h0, core_oe, core_out}, "tlr pads");
    chk(33'(ser_out_oe), 33'h0, "tlr drive");
    u_bst_tester.tick(1'b0, 1'b0, b);
    u_bst_tester.dr(32, din, got);
    chk(got, ID_EXP, "id after tms reset");
    $display("mode-select reset test done");
    // pin reset while extest holds the pads
    u_bst_tester.ir(bst_pkg::OP_EXTEST, got);
    test_rst_n = 1'b0;
    repeat (5) @(negedge clock);
    test_rst_n = 1'b1;
    repeat (4) @(negedge clock);
    chk({25'h0, pin_oe, pin_out}, {25'h0, core_oe, core_out}, "trst pads");
    u_bst_tester.tick(1'b0, 1'b0, b);
    // identification scan split by a pause
    u_bst_tester.enter(1'b0);
    u_bst_tester.shift(16, din, got, 1'b0);
    u_bst_tester.tick(1'b0, 1'b0, b);
    u_bst_tester.tick(1'b0, 1'b0, b);
    u_bst_tester.tick(1'b1, 1'b0, b);
    u_bst_tester.tick(1'b0, 1'b0, b);
    u_bst_tester.shift(16, din >> 16, e, 1'b1);
    chk({1'b0, e[15:0], got[15:0]}, ID_EXP, "paused id");
    $display("pin reset and pause test done");
    // a test clock pulse while frozen must be ignored, else the scan lands on the ir path
    ce = 1'b0;
    u_bst_tester.tick(1'b1, 1'b0, b);
    ce = 1'b1;
    u_bst_tester.dr(32, din, got);
    chk(got, ID_EXP, "id after frozen tick");
    $display("clock enable test done");
    final_report();
  end
endmodule

// ===== hw/bst_pkg.sv
// shared constants and types for the boundary-scan test access port
package bst_pkg;

  // instruction register geometry and decode
  localparam int          IR_W       = 4;
  localparam logic [3:0]  OP_EXTEST  = 4'h0;
  localparam logic [3:0]  OP_SAMPLE  = 4'h1;
  localparam logic [3:0]  OP_IDCODE  = 4'h2;
  localparam logic [3:0]  OP_HIGHZ   = 4'h3;
  localparam logic [3:0]  OP_BYPASS  = 4'hf;

  // capture pattern: the two low bits must read 01
  localparam logic [3:0]  IR_CAPTURE = 4'h1;

  // reset and capture values
  localparam logic [3:0]  IR_RESET   = OP_IDCODE;
  localparam logic        BYP_CAPTURE = 1'b0;

  // identification word layout
  localparam int          ID_W       = 32;
  localparam int          ID_VER_W   = 4;
  localparam int          ID_PART_W  = 16;
  localparam int          ID_MFR_W   = 11;
  localparam int          ID_VER_LSB = 28;
  localparam int          ID_PART_LSB = 12;
  localparam int          ID_MFR_LSB = 1;
  localparam logic        ID_LSB_ONE = 1'b1;

  // consecutive high mode-select edges that force reset
  localparam logic [2:0]  TMS_RESET_EDGES = 3'h5;

  // controller states, one-hot
  typedef enum logic [15:0] {
    S_TLR   = 16'h0001,
    S_RTI   = 16'h0002,
    S_SELDR = 16'h0004,
    S_CAPDR = 16'h0008,
    S_SHDR  = 16'h0010,
    S_EX1DR = 16'h0020,
    S_PSDR  = 16'h0040,
    S_EX2DR = 16'h0080,
    S_UPDR  = 16'h0100,
    S_SELIR = 16'h0200,
    S_CAPIR = 16'h0400,
    S_SHIR  = 16'h0800,
    S_EX1IR = 16'h1000,
    S_PSIR  = 16'h2000,
    S_EX2IR = 16'h4000,
    S_UPIR  = 16'h8000
  } bst_tap_t;

  // test access pins as they arrive from the tester
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_t;

endpackage

// ===== hw/bst_tap.sv
// boundary-scan test access port: controller, instruction and data registers
//
// Summary of operation
// - state moves only on test clock rise, reset pin or power-up reset
// - five high mode-select edges force reset state
// - reset state leaves device fully functional
// - run-test-idle does nothing for these instructions
// - capture-ir loads pattern ending in 01
// - shift-ir shifts instruction one bit per rise
// - pause-ir holds instruction shift stages
// - update-ir latches instruction on falling edge only
// - capture-dr loads register chosen by instruction
// - data path states mirror instruction path
// - four-bit instruction, lsb nearest serial output
// - data registers share serial input and output
// - bypass is one stage capturing zero
// - 32-bit read-only identification shift register
// - id: version, part, manufacturer, lsb one
// - code 0 drives pins from boundary cells
// - code 2 selects identification, device undisturbed
// - identification is default after reset
// - code 1 samples or preloads boundary cells
// - code 3 floats outputs, selects bypass
// - code f selects bypass, device unaffected
// - controller reset by pin or mode-select sequence
// - test logic resets itself at power-up
`timescale 1ns/1ps

module bst_tap #(
  parameter int         N_IN    = 4,
  parameter int         N_OUT   = 4,
  // identification fields, values arbitrary
  parameter logic [3:0]  ID_VER  = 4'h1,
  parameter logic [15:0] ID_PART = 16'h0abc,
  parameter logic [10:0] ID_MFR  = 11'h2a5
) (
  // system
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             ce,
  // test access pins
  input  wire logic             test_clock_alt,
  input  wire logic             mode_sel,
  input  wire logic             ser_in,
  input  wire logic             test_rst_n,
  output logic                  ser_out,
  output logic                  ser_out_oe,
  // functional core side
  input  wire logic [N_OUT-1:0] core_out,
  input  wire logic [N_OUT-1:0] core_oe,
  output logic      [N_IN-1:0]  core_in,
  // device pads
  input  wire logic [N_IN-1:0]  pin_in,
  output logic      [N_OUT-1:0] pin_out,
  output logic      [N_OUT-1:0] pin_oe
);

  // boundary chain: inputs at the serial-output end, then output data, then enables
  localparam int BS_LEN = N_IN + 2 * N_OUT;
  localparam int OD_LSB = N_IN;
  localparam int OE_LSB = N_IN + N_OUT;

  localparam logic [31:0] ID_VALUE = {ID_VER, ID_PART, ID_MFR, bst_pkg::ID_LSB_ONE};

  typedef struct packed {
    bst_pkg::bst_pins_t s1;
    bst_pkg::bst_pins_t s2;
    logic               tck_prev;
    logic [N_IN-1:0]    pin_s1;
    logic [N_IN-1:0]    pin_s2;
    bst_pkg::bst_tap_t  st;
    logic [2:0]         tms_ones;
    logic [3:0]         ir_sh;
    logic [3:0]         ir;
    logic               byp;
    logic [31:0]        id_sh;
    logic [BS_LEN-1:0]  bs_sh;
    logic [BS_LEN-1:0]  bs_up;
    logic               tdo;
    logic               tdo_oe;
    logic [N_OUT-1:0]   pout;
    logic [N_OUT-1:0]   poe;
  } bst_regs_t;

  bst_regs_t q;
  bst_regs_t d;

  function automatic bst_pkg::bst_tap_t tap_next(input bst_pkg::bst_tap_t s,
                                                 input logic m);
    unique case (s)
      bst_pkg::S_TLR:   return m ? bst_pkg::S_TLR   : bst_pkg::S_RTI;
      bst_pkg::S_RTI:   return m ? bst_pkg::S_SELDR : bst_pkg::S_RTI;
      bst_pkg::S_SELDR: return m ? bst_pkg::S_SELIR : bst_pkg::S_CAPDR;
      bst_pkg::S_CAPDR: return m ? bst_pkg::S_EX1DR : bst_pkg::S_SHDR;
      bst_pkg::S_SHDR:  return m ? bst_pkg::S_EX1DR : bst_pkg::S_SHDR;
      bst_pkg::S_EX1DR: return m ? bst_pkg::S_UPDR  : bst_pkg::S_PSDR;
      bst_pkg::S_PSDR:  return m ? bst_pkg::S_EX2DR : bst_pkg::S_PSDR;
      bst_pkg::S_EX2DR: return m ? bst_pkg::S_UPDR  : bst_pkg::S_SHDR;
      bst_pkg::S_UPDR:  return m ? bst_pkg::S_SELDR : bst_pkg::S_RTI;
      bst_pkg::S_SELIR: return m ? bst_pkg::S_TLR   : bst_pkg::S_CAPIR;
      bst_pkg::S_CAPIR: return m ? bst_pkg::S_EX1IR : bst_pkg::S_SHIR;
      bst_pkg::S_SHIR:  return m ? bst_pkg::S_EX1IR : bst_pkg::S_SHIR;
      bst_pkg::S_EX1IR: return m ? bst_pkg::S_UPIR  : bst_pkg::S_PSIR;
      bst_pkg::S_PSIR:  return m ? bst_pkg::S_EX2IR : bst_pkg::S_PSIR;
      bst_pkg::S_EX2IR: return m ? bst_pkg::S_UPIR  : bst_pkg::S_SHIR;
      bst_pkg::S_UPIR:  return m ? bst_pkg::S_SELDR : bst_pkg::S_RTI;
      // an upset code falls back to the safe state
      default:          return bst_pkg::S_TLR;
    endcase
  endfunction

  // test clock edges, found from the second sync stage only
  logic rise;
  logic fall;
  assign rise = q.s2.tck & ~q.tck_prev;
  assign fall = ~q.s2.tck & q.tck_prev;

  // register selection
  logic sel_bs;
  logic sel_id;
  logic dr_lsb;
  assign sel_bs = (q.ir == bst_pkg::OP_EXTEST) || (q.ir == bst_pkg::OP_SAMPLE);
  assign sel_id = (q.ir == bst_pkg::OP_IDCODE);
  // everything else, high-impedance and unassigned codes included, uses bypass
  assign dr_lsb = sel_bs ? q.bs_sh[0] : (sel_id ? q.id_sh[0] : q.byp);

  always_comb begin
    d = q;
    d.s1 = '{tck: test_clock_alt, tms: mode_sel, tdi: ser_in, trst_n: test_rst_n};
    d.s2 = q.s1;
    d.tck_prev = q.s2.tck;
    d.pin_s1 = pin_in;
    d.pin_s2 = q.pin_s1;

    if (rise) begin
      d.st = tap_next(q.st, q.s2.tms);
      if (!q.s2.tms) begin
        d.tms_ones = 3'h0;
      end else if (q.tms_ones != bst_pkg::TMS_RESET_EDGES) begin
        d.tms_ones = q.tms_ones + 3'h1;
      end

      // rising-edge register actions use the state being left
      unique case (q.st)
        bst_pkg::S_CAPIR: d.ir_sh = bst_pkg::IR_CAPTURE;
        bst_pkg::S_SHIR:  d.ir_sh = {q.s2.tdi, q.ir_sh[3:1]};
        bst_pkg::S_CAPDR: begin
          if (sel_bs) begin
            d.bs_sh = {core_oe, core_out, q.pin_s2};
          end else if (sel_id) begin
            d.id_sh = ID_VALUE;
          end else begin
            d.byp = bst_pkg::BYP_CAPTURE;
          end
        end
        bst_pkg::S_SHDR: begin
          if (sel_bs) begin
            d.bs_sh = {q.s2.tdi, q.bs_sh[BS_LEN-1:1]};
          end else if (sel_id) begin
            d.id_sh = {q.s2.tdi, q.id_sh[31:1]};
          end else begin
            d.byp = q.s2.tdi;
          end
        end
        // pause, exit, select and idle states leave the shift stages alone
        default: ;
      endcase
    end

    if (fall) begin
      if (q.st == bst_pkg::S_UPIR) begin
        d.ir = q.ir_sh;
      end
      if (q.st == bst_pkg::S_UPDR && sel_bs) begin
        d.bs_up = q.bs_sh;
      end
      // output only launched on the fall so the tester samples it on the next rise
      if (q.st == bst_pkg::S_SHIR) begin
        d.tdo = q.ir_sh[0];
        d.tdo_oe = 1'b1;
      end else if (q.st == bst_pkg::S_SHDR) begin
        d.tdo = dr_lsb;
        d.tdo_oe = 1'b1;
      end else begin
        d.tdo = 1'b0;
        d.tdo_oe = 1'b0;
      end
    end

    // the optional reset pin wins over any clocked move
    if (!q.s2.trst_n) begin
      d.st = bst_pkg::S_TLR;
      d.tms_ones = 3'h0;
      d.tdo = 1'b0;
      d.tdo_oe = 1'b0;
    end

    // in reset state the default instruction is reloaded on every system clock with ce high
    if (q.st == bst_pkg::S_TLR) begin
      d.ir = bst_pkg::IR_RESET;
    end

    // pad drive, registered one system clock behind the instruction
    if (q.ir == bst_pkg::OP_EXTEST && q.st != bst_pkg::S_TLR) begin
      d.pout = q.bs_up[OD_LSB +: N_OUT];
      d.poe = q.bs_up[OE_LSB +: N_OUT];
    end else if (q.ir == bst_pkg::OP_HIGHZ && q.st != bst_pkg::S_TLR) begin
      d.pout = core_out;
      d.poe = '0;
    end else begin
      d.pout = core_out;
      d.poe = core_oe;
    end
  end

  // power-up reset puts the controller straight into reset state
  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= '0;
      q.s1.trst_n <= 1'b1;
      q.s2.trst_n <= 1'b1;
      q.st <= bst_pkg::S_TLR;
      q.ir <= bst_pkg::IR_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  assign ser_out = q.tdo;
  assign ser_out_oe = q.tdo_oe;
  assign core_in = q.pin_s2;
  assign pin_out = q.pout;
  assign pin_oe = q.poe;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_rise_at(bst_pkg::bst_tap_t s);
    ce && rise && q.s2.trst_n && q.st == s;
  endsequence

  sequence s_fall_at(bst_pkg::bst_tap_t s);
    ce && fall && q.s2.trst_n && q.st == s;
  endsequence

  a_state_no_edge: assert property (
    !(ce && rise) && q.s2.trst_n |=> $stable(q.st))
    else $error("state moved without a test clock rise");

  a_five_ones: assert property (
    q.tms_ones == bst_pkg::TMS_RESET_EDGES |-> q.st == bst_pkg::S_TLR)
    else $error("five high mode-select edges did not reset");

  a_capture_ir: assert property (
    s_rise_at(bst_pkg::S_CAPIR) |=> q.ir_sh[1:0] == 2'b01)
    else $error("capture-ir pattern wrong");

  a_shift_ir: assert property (
    s_rise_at(bst_pkg::S_SHIR) |=> q.ir_sh == {$past(q.s2.tdi), $past(q.ir_sh[3:1])})
    else $error("instruction shift wrong");

  a_pause_hold: assert property (
    ce && q.st == bst_pkg::S_PSIR ##1 q.st == bst_pkg::S_PSIR |-> $stable(q.ir_sh))
    else $error("instruction stages moved in pause");

  a_ir_latch_when: assert property (
    ce && $changed(q.ir) |-> $past(q.st) == bst_pkg::S_TLR
      || ($past(q.st) == bst_pkg::S_UPIR && $past(fall)))
    else $error("instruction changed outside update or reset");

  a_bypass_zero: assert property (
    s_rise_at(bst_pkg::S_CAPDR) and !sel_bs && !sel_id |=> q.byp == 1'b0)
    else $error("bypass did not capture zero");

  a_id_capture: assert property (
    s_rise_at(bst_pkg::S_CAPDR) and sel_id |=> q.id_sh == ID_VALUE && q.id_sh[0])
    else $error("identification capture wrong");

  a_default_id: assert property (
    ce && q.st == bst_pkg::S_TLR |=> q.ir == bst_pkg::OP_IDCODE)
    else $error("reset state did not restore identification");

  a_highz_pins: assert property (
    ce && q.ir == bst_pkg::OP_HIGHZ && q.st != bst_pkg::S_TLR |=> q.poe == '0)
    else $error("outputs enabled under high-impedance");

  a_extest_pins: assert property (
    ce && q.ir == bst_pkg::OP_EXTEST && q.st != bst_pkg::S_TLR
      |=> q.pout == $past(q.bs_up[OD_LSB +: N_OUT]))
    else $error("pins not driven from boundary cells");

  a_tdo_drive: assert property (
    s_fall_at(bst_pkg::S_SHDR) |=> q.tdo_oe && q.tdo == $past(dr_lsb))
    else $error("serial output not driven in shift-dr");

  a_tdo_idle: assert property (
    q.st == bst_pkg::S_TLR |-> !q.tdo_oe)
    else $error("serial output driven in reset state");

  a_tdo_ir: assert property (
    s_fall_at(bst_pkg::S_SHIR) |=> q.tdo_oe && q.tdo == $past(q.ir_sh[0]))
    else $error("serial output wrong in shift-ir");

  a_ir_update: assert property (
    s_fall_at(bst_pkg::S_UPIR) |=> q.ir == $past(q.ir_sh))
    else $error("instruction not latched in update-ir");

  a_bypass_shift: assert property (
    s_rise_at(bst_pkg::S_SHDR) and !sel_bs && !sel_id |=> q.byp == $past(q.s2.tdi))
    else $error("bypass stage did not shift");

  a_id_shift: assert property (
    s_rise_at(bst_pkg::S_SHDR) and sel_id |=> q.id_sh == {$past(q.s2.tdi), $past(q.id_sh[31:1])})
    else $error("identification shift wrong");

  a_bs_capture: assert property (
    s_rise_at(bst_pkg::S_CAPDR) and sel_bs
      |=> q.bs_sh == {$past(core_oe), $past(core_out), $past(q.pin_s2)})
    else $error("boundary capture wrong");

  a_bs_update: assert property (
    s_fall_at(bst_pkg::S_UPDR) and sel_bs |=> q.bs_up == $past(q.bs_sh))
    else $error("boundary update wrong");

  a_dr_pause: assert property (
    ce && q.st == bst_pkg::S_PSDR ##1 q.st == bst_pkg::S_PSDR
      |-> $stable(q.bs_sh) && $stable(q.id_sh) && $stable(q.byp))
    else $error("data stages moved in pause");

  a_idle_quiet: assert property (
    ce && q.st == bst_pkg::S_RTI ##1 q.st == bst_pkg::S_RTI
      |-> $stable(q.ir_sh) && $stable(q.bs_sh) && $stable(q.id_sh) && $stable(q.byp))
    else $error("test registers moved in run-test-idle");

  a_trst_wins: assert property (
    ce && !q.s2.trst_n |=> q.st == bst_pkg::S_TLR && !q.tdo_oe)
    else $error("reset pin did not force reset state");

  a_tlr_pins: assert property (
    ce && q.st == bst_pkg::S_TLR |=> q.pout == $past(core_out) && q.poe == $past(core_oe))
    else $error("pads not functional in reset state");

endmodule
